// [hdl/dsleep_pkg.sv]
package dsleep_pkg;

	// ---------------------------------------------------------------
	// Register map, byte addresses on the bus.
	// ---------------------------------------------------------------
	localparam logic [11:0] ADDR_UNLOCK  = 12'h000; // Unlock key register.
	localparam logic [11:0] ADDR_CTRL    = 12'h004; // Sleep control register.
	localparam logic [11:0] ADDR_CONFIG  = 12'h008; // Config word two image.
	localparam logic [11:0] ADDR_STATUS  = 12'h00c; // Power state status.
	localparam logic [11:0] ADDR_GP_ZERO = 12'h010; // Persistent register.
	localparam logic [11:0] ADDR_GP_BASE = 12'h080; // Gated registers 1..32.

	// Gated register window decode: upper bits select, index bits pick.
	localparam int          GP_COUNT   = 32;
	localparam int          GP_IDX_LSB = 2;
	localparam int          GP_IDX_MSB = 6;
	localparam int          GP_SEL_LSB = 7;
	localparam logic [4:0]  GP_SEL_VAL = 5'h01;

	// ---------------------------------------------------------------
	// Field positions.
	// ---------------------------------------------------------------
	localparam int CTRL_ENTRY_BIT   = 15; // Deep sleep entry enable.
	localparam int CTRL_RETAIN_BIT  = 13; // Gated register retention.
	localparam int CTRL_CALDIS_BIT  = 12; // Calendar off in deep sleep.
	localparam int CTRL_RELEASE_BIT = 0;  // Pin state release.
	localparam int CFG_WDT_EN_BIT   = 27; // Sleep watchdog enable.
	localparam int CFG_WDT_CLK_BIT  = 26; // Sleep watchdog clock select.
	localparam int CFG_BOR_BIT      = 20; // Sleep brown-out enable.
	localparam int STAT_STATE_LSB   = 0;  // Two-bit power state.
	localparam int STAT_UNLOCK_BIT  = 2;  // Unlock sequence done.
	localparam int STAT_PEND_BIT    = 3;  // First of two writes held.

	// Writable bits of the sleep control register and reset values.
	localparam logic [31:0] CTRL_WRITE_MASK = 32'h0000b001;
	localparam logic [31:0] CTRL_RESET      = 32'h00000000;
	localparam logic [31:0] DATA_ZERO       = 32'h00000000;

	// Unlock keys; values are arbitrary.
	localparam logic [31:0] UNLOCK_KEY_A = 32'h5a5a1234;
	localparam logic [31:0] UNLOCK_KEY_B = 32'ha5a54321;

	// Power states of the sequencer.
	typedef enum logic [1:0] {PWR_RUN, PWR_DEEP_SLEEP, PWR_BATTERY}
		power_state_t;

endpackage

// [hdl/dw_if.sv]
`timescale 1ns/100ps
// Write stream into the double-write check and its commit answer.
interface dw_if;
	logic        wrEn;       // One bus write to a guarded register.
	logic [11:0] wrAddr;     // Address of that write.
	logic [31:0] wrData;     // Data of that write.
	logic        commit;     // Pulse: second matching write seen.
	logic [11:0] commitAddr; // Address to commit.
	logic [31:0] commitData; // Data to commit.
	logic        pending;    // A first write is held.

	modport gate (input wrEn, wrAddr, wrData,
		output commit, commitAddr, commitData, pending);
	modport user (output wrEn, wrAddr, wrData,
		input commit, commitAddr, commitData, pending);
endinterface

// [hdl/double_write_gate.sv]
`timescale 1ns/100ps
// Holds the first write to a guarded register and commits only when the
// very next guarded write repeats the same address and data.
module double_write_gate
(
	input  wire logic core_clk,
	input  wire logic rst,
	dw_if.gate        dw
);

	logic held; // A first write waits for its twin.

	// ---------------------------------------------------------------
	// Pair check.
	// ---------------------------------------------------------------
	// A mismatching write replaces the held one, so a torn pair during a
	// supply dip never reaches the register.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			held          <= 1'b0;
			dw.commit     <= 1'b0;
			dw.commitAddr <= 12'h000;
			dw.commitData <= dsleep_pkg::DATA_ZERO;
		end
		else if (dw.wrEn)
		begin
			if (held && dw.wrAddr == dw.commitAddr
				&& dw.wrData == dw.commitData)
			begin
				// Second matching write: release the value.
				held      <= 1'b0;
				dw.commit <= 1'b1;
			end
			else
			begin
				// First write, or a twin that disagrees: hold it.
				held          <= 1'b1;
				dw.commit     <= 1'b0;
				dw.commitAddr <= dw.wrAddr;
				dw.commitData <= dw.wrData;
			end
		end
		else
		begin
			dw.commit <= 1'b0;
		end
	end

	assign dw.pending = held;

endmodule // double_write_gate

// [hdl/deep_sleep_retention_control.sv]
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/100ps
module deep_sleep_retention_control
(
	input  wire logic        core_clk,          // System clock.
	input  wire logic        rst,               // Synchronous reset.
	input  wire logic        psel,              // Bus select.
	input  wire logic        penable,           // Bus access phase.
	input  wire logic        pwrite,            // Bus direction.
	input  wire logic [11:0] paddr,             // Bus byte address.
	input  wire logic [31:0] pwdata,            // Bus write data.
	output logic      [31:0] prdata,            // Bus read data.
	output logic             pready,            // Bus answer.
	output logic             pslverr,           // Unmapped address.
	input  wire logic [31:0] deviceConfigWord,  // Config word two strap.
	input  wire logic        waitSleepReq,      // Core wait with sleep.
	input  wire logic        mainSupplyOk,      // Main supply above POR.
	input  wire logic        masterClearPinN,   // Master clear pin level.
	input  wire logic        extIrqZeroPin,     // Interrupt zero pin.
	input  wire logic        calendarAlarm,     // Calendar wake event.
	input  wire logic        watchdogTimeout,   // Sleep watchdog expiry.
	output logic             corePowerOn,       // Core, RAM, peripherals.
	output logic             calendarPowerOn,   // Calendar clock domain.
	output logic             watchdogRun,       // Sleep watchdog active.
	output logic             watchdogClockSel,  // Sleep watchdog clock.
	output logic             gatedRegPowerOn,   // Gated registers 1..32.
	output logic             persistentPowerOn, // Register zero domain.
	output logic             wakePinsEnabled,   // Clear and irq pins live.
	output logic             sleepBrownoutArmed,// Brown-out in deep sleep.
	output logic             runFromBattery,    // Backup supply selected.
	output logic             pinStateHeld,      // Release bit state.
	output logic             powerOnResetPulse  // Exit from battery mode.
);

	// ---------------------------------------------------------------
	// Storage.
	// ---------------------------------------------------------------
	dsleep_pkg::power_state_t state;      // Current power state.
	dsleep_pkg::power_state_t next_state; // Power state to take.
	logic [31:0] sleepCtrl;               // Sleep control register.
	logic [31:0] configWord;              // Latched config word two.
	logic [31:0] gpZero;                  // Persistent register zero.
	localparam int GP_LAST = dsleep_pkg::GP_COUNT; // Last gated index.
	logic [31:0] gpRegs [1:GP_LAST];      // Gated registers 1..32.
	logic        keyStage;                // First key seen.
	logic        unlocked;                // Unlock sequence complete.
	logic        losingGated;             // Gated contents dropped.

	dw_if dw ();

	// ---------------------------------------------------------------
	// Bus decode.
	// ---------------------------------------------------------------
	logic        busWrite;  // Write taken at this edge.
	logic        busRead;   // Read taken at this edge.
	logic        hitGated;  // Address lies in gated window.
	logic [5:0]  gpIndex;   // Gated register number, 1..32.
	logic        mapped;    // Address is a register.

	// A write is taken at the edge where pready is already high, a read at the edge before.
	assign busWrite = psel && penable && pready && pwrite;
	assign busRead  = psel && penable && !pready && !pwrite;
	assign hitGated = paddr[11:dsleep_pkg::GP_SEL_LSB]
		== dsleep_pkg::GP_SEL_VAL;
	assign gpIndex  = {1'b0, paddr[dsleep_pkg::GP_IDX_MSB:
		dsleep_pkg::GP_IDX_LSB]} + 6'h01;
	assign mapped   = hitGated
		|| paddr == dsleep_pkg::ADDR_UNLOCK
		|| paddr == dsleep_pkg::ADDR_CTRL
		|| paddr == dsleep_pkg::ADDR_CONFIG
		|| paddr == dsleep_pkg::ADDR_STATUS
		|| paddr == dsleep_pkg::ADDR_GP_ZERO;

	// ---------------------------------------------------------------
	// Bus answer.
	// ---------------------------------------------------------------
	// Ready rises one cycle into the access phase and falls after the
	// completing edge, so every transfer takes exactly one wait state.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !mapped;
		end
	end

	// Read data is captured in the cycle before ready rises.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			prdata <= dsleep_pkg::DATA_ZERO;
		end
		else if (busRead)
		begin
			if (hitGated)
			begin
				prdata <= gpRegs[gpIndex];
			end
			else
			begin
				unique case (paddr)
					dsleep_pkg::ADDR_CTRL:    prdata <= sleepCtrl;
					dsleep_pkg::ADDR_CONFIG:  prdata <= configWord;
					dsleep_pkg::ADDR_GP_ZERO: prdata <= gpZero;
					dsleep_pkg::ADDR_STATUS:
					begin
						prdata <= dsleep_pkg::DATA_ZERO;
						prdata[dsleep_pkg::STAT_STATE_LSB +: 2] <= state;
						prdata[dsleep_pkg::STAT_UNLOCK_BIT] <= unlocked;
						prdata[dsleep_pkg::STAT_PEND_BIT] <= dw.pending;
					end
					// Key register and unmapped holes read as zero.
					default: prdata <= dsleep_pkg::DATA_ZERO;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Unlock sequence.
	// ---------------------------------------------------------------
	// Two keys in a row open the control register; a committed control
	// write or a wrong key closes it again.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			keyStage <= 1'b0;
			unlocked <= 1'b0;
		end
		else if (busWrite && paddr == dsleep_pkg::ADDR_UNLOCK)
		begin
			keyStage <= pwdata == dsleep_pkg::UNLOCK_KEY_A;
			unlocked <= keyStage && pwdata == dsleep_pkg::UNLOCK_KEY_B;
		end
		else if (dw.commit && dw.commitAddr == dsleep_pkg::ADDR_CTRL)
		begin
			unlocked <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Double-write check for guarded registers.
	// ---------------------------------------------------------------
	// Control writes while locked never reach the check at all.
	assign dw.wrEn   = busWrite && (hitGated
		|| (paddr == dsleep_pkg::ADDR_CTRL && unlocked));
	assign dw.wrAddr = paddr;
	assign dw.wrData = pwdata;

	double_write_gate i_double_write_gate
	(
		.core_clk (core_clk),
		.rst      (rst),
		.dw       (dw)
	);

	// ---------------------------------------------------------------
	// Sleep control register.
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			sleepCtrl <= dsleep_pkg::CTRL_RESET;
		end
		else if (dw.commit && dw.commitAddr == dsleep_pkg::ADDR_CTRL)
		begin
			sleepCtrl <= dw.commitData & dsleep_pkg::CTRL_WRITE_MASK;
		end
	end

	// Config word two is a strap, caught while reset is held.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			configWord <= deviceConfigWord;
		end
	end

	// ---------------------------------------------------------------
	// Persistent register zero.
	// ---------------------------------------------------------------
	// Never cleared by any sleep or battery transition.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			gpZero <= dsleep_pkg::DATA_ZERO;
		end
		else if (busWrite && paddr == dsleep_pkg::ADDR_GP_ZERO)
		begin
			gpZero <= pwdata;
		end
	end

	// ---------------------------------------------------------------
	// Gated registers 1..32.
	// ---------------------------------------------------------------
	// Without retention, contents are wiped when power leaves them.
	assign losingGated = state == dsleep_pkg::PWR_RUN
		&& next_state != dsleep_pkg::PWR_RUN
		&& !sleepCtrl[dsleep_pkg::CTRL_RETAIN_BIT];

	always_ff @(posedge core_clk)
	begin
		if (rst || losingGated)
		begin
			for (int i = 1; i <= GP_LAST; i++)
			begin
				gpRegs[i] <= dsleep_pkg::DATA_ZERO;
			end
		end
		else if (dw.commit && dw.commitAddr[11:dsleep_pkg::GP_SEL_LSB]
			== dsleep_pkg::GP_SEL_VAL)
		begin
			gpRegs[{1'b0, dw.commitAddr[dsleep_pkg::GP_IDX_MSB:
				dsleep_pkg::GP_IDX_LSB]} + 6'h01] <= dw.commitData;
		end
	end

	// ---------------------------------------------------------------
	// Power state machine.
	// ---------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		if (!mainSupplyOk)
		begin
			next_state = dsleep_pkg::PWR_BATTERY;
		end
		else
		begin
			unique case (state)
				dsleep_pkg::PWR_RUN:
				begin
					if (waitSleepReq
						&& sleepCtrl[dsleep_pkg::CTRL_ENTRY_BIT])
					begin
						next_state = dsleep_pkg::PWR_DEEP_SLEEP;
					end
				end
				dsleep_pkg::PWR_DEEP_SLEEP:
				begin
					// Only live domains may wake the device.
					if (!masterClearPinN || extIrqZeroPin
						|| (calendarAlarm && calendarPowerOn)
						|| (watchdogTimeout && watchdogRun))
					begin
						next_state = dsleep_pkg::PWR_RUN;
					end
				end
				dsleep_pkg::PWR_BATTERY:
				begin
					next_state = dsleep_pkg::PWR_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state <= dsleep_pkg::PWR_RUN;
		end
		else
		begin
			state <= next_state;
		end
	end

	// ---------------------------------------------------------------
	// Domain power and pin outputs.
	// ---------------------------------------------------------------
	// Outputs follow the state one edge later, so a domain switches
	// off only after the state change is settled.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			corePowerOn        <= 1'b1;
			calendarPowerOn    <= 1'b1;
			watchdogRun        <= 1'b0;
			gatedRegPowerOn    <= 1'b1;
			wakePinsEnabled    <= 1'b1;
			runFromBattery     <= 1'b0;
		end
		else
		begin
			// Core, RAM and most peripherals run only in run state.
			corePowerOn     <= state == dsleep_pkg::PWR_RUN;
			// Calendar stays on unless out of run state with its disable bit set.
			calendarPowerOn <= state == dsleep_pkg::PWR_RUN
				|| !sleepCtrl[dsleep_pkg::CTRL_CALDIS_BIT];
			// Watchdog only in deep sleep, never on the backup supply.
			watchdogRun     <= state == dsleep_pkg::PWR_DEEP_SLEEP
				&& configWord[dsleep_pkg::CFG_WDT_EN_BIT];
			gatedRegPowerOn <= state == dsleep_pkg::PWR_RUN
				|| sleepCtrl[dsleep_pkg::CTRL_RETAIN_BIT];
			wakePinsEnabled <= state != dsleep_pkg::PWR_BATTERY;
			runFromBattery  <= state == dsleep_pkg::PWR_BATTERY;
		end
	end

	// Persistent domain, configuration and sleep brown-out outputs.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			persistentPowerOn  <= 1'b1;
			watchdogClockSel   <= 1'b0;
			sleepBrownoutArmed <= 1'b0;
			pinStateHeld       <= 1'b0;
		end
		else
		begin
			persistentPowerOn  <= 1'b1;
			watchdogClockSel   <= configWord[dsleep_pkg::CFG_WDT_CLK_BIT];
			sleepBrownoutArmed <= state == dsleep_pkg::PWR_DEEP_SLEEP
				&& configWord[dsleep_pkg::CFG_BOR_BIT];
			pinStateHeld       <= sleepCtrl[dsleep_pkg::CTRL_RELEASE_BIT];
		end
	end

	// ---------------------------------------------------------------
	// Power-on reset on leaving battery mode.
	// ---------------------------------------------------------------
	// One pulse when the main supply returns; the rest of the device
	// treats it as a cold start.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			powerOnResetPulse <= 1'b0;
		end
		else
		begin
			powerOnResetPulse <= state == dsleep_pkg::PWR_BATTERY
				&& next_state == dsleep_pkg::PWR_RUN;
		end
	end

endmodule // deep_sleep_retention_control

// [testbench/deep_sleep_retention_control_properties.sv]
`timescale 1ns/100ps
// ----------------------------------------
// Port checks of the sleep sequencer.
// ----------------------------------------
module deep_sleep_retention_control_properties
(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic [31:0] deviceConfigWord,
	input  wire logic        mainSupplyOk,
	input  wire logic        corePowerOn,
	input  wire logic        watchdogRun,
	input  wire logic        persistentPowerOn,
	input  wire logic        wakePinsEnabled,
	input  wire logic        sleepBrownoutArmed,
	input  wire logic        runFromBattery,
	input  wire logic        powerOnResetPulse
);
	// All checks use the system clock and rest in reset.
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	AST_PERSIST: assert property (persistentPowerOn)
		else $error("Register zero domain unpowered.");
	AST_BAT_ENTRY: assert property ($fell(mainSupplyOk) |-> ##[1:3] runFromBattery)
		else $error("Battery mode not entered.");
	AST_BAT_EXIT: assert property ($rose(mainSupplyOk) && runFromBattery
		|-> ##[1:3] powerOnResetPulse)
		else $error("No power-on pulse on exit.");
	AST_POR_ONE: assert property (powerOnResetPulse |=> !powerOnResetPulse)
		else $error("Power-on pulse too long.");
	AST_POR_CAUSE: assert property ($rose(powerOnResetPulse)
		|-> $past(runFromBattery) || $past(runFromBattery, 2))
		else $error("Power-on pulse without battery exit.");
	AST_BAT_WDT: assert property (runFromBattery |-> !watchdogRun && !corePowerOn)
		else $error("Watchdog or core on in battery.");
	AST_WDT_RUN: assert property (watchdogRun
		|-> !corePowerOn
		&& deviceConfigWord[dsleep_pkg::CFG_WDT_EN_BIT])
		else $error("Watchdog runs when not allowed.");
	AST_BOR: assert property (sleepBrownoutArmed
		|-> !corePowerOn
		&& deviceConfigWord[dsleep_pkg::CFG_BOR_BIT])
		else $error("Brown-out armed wrongly.");
	AST_WAKE: assert property (!runFromBattery |-> wakePinsEnabled)
		else $error("Wake pins disabled.");
	AST_APB_WAIT: assert property (psel && !penable
		|-> ##2 (pready && psel && penable))
		else $error("Bus answer late.");
	AST_APB_ERR: assert property (pslverr |-> pready)
		else $error("Error without answer.");

	// Main scenarios reached.
	cover property (watchdogRun);
	cover property (powerOnResetPulse);
	cover property (pslverr);
	cover property (runFromBattery);
endmodule // deep_sleep_retention_control_properties

bind deep_sleep_retention_control deep_sleep_retention_control_properties
	i_deep_sleep_retention_control_properties
(
	.core_clk           (core_clk),
	.rst                (rst),
	.psel               (psel),
	.penable            (penable),
	.pready             (pready),
	.pslverr            (pslverr),
	.deviceConfigWord   (deviceConfigWord),
	.mainSupplyOk       (mainSupplyOk),
	.corePowerOn        (corePowerOn),
	.watchdogRun        (watchdogRun),
	.persistentPowerOn  (persistentPowerOn),
	.wakePinsEnabled    (wakePinsEnabled),
	.sleepBrownoutArmed (sleepBrownoutArmed),
	.runFromBattery     (runFromBattery),
	.powerOnResetPulse  (powerOnResetPulse)
);

// [testbench/deep_sleep_retention_control_tb.sv]
`timescale 1ns/100ps
module deep_sleep_retention_control_tb;
	// ----------------------------------------
	// Signals and stimulus table.
	// ----------------------------------------
	localparam logic [31:0] CFG = 32'h0c100000; // Watchdog, clock, BOR.
	logic        core_clk = 1'b0; // System clock.
	logic        rst = 1'b1;      // Held high at start.
	logic        psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, deviceConfigWord;
	logic        er, waitSleepReq, mainSupplyOk, masterClearPinN;
	logic        extIrqZeroPin, calendarAlarm, watchdogTimeout;
	logic        corePowerOn, calendarPowerOn, watchdogRun;
	logic        watchdogClockSel, gatedRegPowerOn, persistentPowerOn;
	logic        wakePinsEnabled, sleepBrownoutArmed, runFromBattery;
	logic        pinStateHeld, powerOnResetPulse;
	logic [34:0] row;         // Expected core, calendar, gated; ctrl.
	int          mismatches, check_count, cycles, seen;
	// Rows: sleep outcome for each control setting.
	logic [34:0] rows [5] = '{{3'b111, 32'h00003000},
		{3'b010, 32'h00008000}, {3'b000, 32'h00009000},
		{3'b011, 32'h0000a000}, {3'b001, 32'h0000b001}};

	deep_sleep_retention_control i_deep_sleep_retention_control (.*);

	// Clock of 20 ns period.
	always #10 core_clk = ~core_clk;

	// Cuts a hang short.
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			end_sim();
		end
	end

	// ----------------------------------------
	// Tasks.
	// ----------------------------------------
	// Compares and reports one value.
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e)
		begin
			mismatches++;
			$display("FAIL %0t got %h expected %h", $time, g, e);
		end
	endtask

	// One bus transfer; read data and error land in rd and er.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20)
			chk(32'h00000000, 32'h00000001);
	endtask

	// Reads a register and compares it.
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h00000000);
		chk(rd, e);
	endtask

	// Writes a guarded register twice.
	task automatic wr2(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		apb(1'b1, a, d);
	endtask

	// Opens control writes with the two keys.
	task automatic unlock();
		apb(1'b1, dsleep_pkg::ADDR_UNLOCK, dsleep_pkg::UNLOCK_KEY_A);
		apb(1'b1, dsleep_pkg::ADDR_UNLOCK, dsleep_pkg::UNLOCK_KEY_B);
	endtask

	// Prints the counts and the verdict, then stops.
	task end_sim();
		$display("Checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence.
	// ----------------------------------------
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{waitSleepReq, extIrqZeroPin, calendarAlarm} = '0;
		watchdogTimeout = 1'b0;
		mainSupplyOk = 1'b1;
		masterClearPinN = 1'b1;
		deviceConfigWord = CFG;
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		// Values after reset.
		rdchk(dsleep_pkg::ADDR_CTRL, 32'h00000000);
		rdchk(dsleep_pkg::ADDR_CONFIG, CFG);
		chk(watchdogClockSel, 1'b1);
		// Each row: set control, sleep, check domains, wake.
		for (int i = 0; i < 5; i++)
		begin
			row = rows[i];
			unlock();
			wr2(dsleep_pkg::ADDR_CTRL, row[31:0]);
			rdchk(dsleep_pkg::ADDR_CTRL, row[31:0]);
			wr2(dsleep_pkg::ADDR_GP_BASE, 32'h00c0ffe0 + i);
			waitSleepReq <= 1'b1;
			repeat (4) @(posedge core_clk);
			chk(corePowerOn, row[34]);
			chk(calendarPowerOn, row[33]);
			chk(gatedRegPowerOn, row[32]);
			chk(watchdogRun, !row[34]);
			chk(sleepBrownoutArmed, !row[34]);
			chk(wakePinsEnabled, 1'b1);
			chk(pinStateHeld, row[0]);
			waitSleepReq <= 1'b0;
			if (i[0])
				masterClearPinN <= 1'b0;
			else
				extIrqZeroPin <= 1'b1;
			repeat (4) @(posedge core_clk);
			masterClearPinN <= 1'b1;
			extIrqZeroPin <= 1'b0;
			chk(corePowerOn, 1'b1);
			rdchk(dsleep_pkg::ADDR_GP_BASE, row[32] ? 32'h00c0ffe0 + i : '0);
		end
		// Control write while locked is ignored.
		wr2(dsleep_pkg::ADDR_CTRL, 32'h00008000);
		rdchk(dsleep_pkg::ADDR_CTRL, 32'h0000b001);
		// Two differing writes never commit.
		unlock();
		apb(1'b1, dsleep_pkg::ADDR_CTRL, 32'h00008001);
		apb(1'b1, dsleep_pkg::ADDR_CTRL, 32'h00009000);
		rdchk(dsleep_pkg::ADDR_CTRL, 32'h0000b001);
		// Unmapped address answers with an error.
		rdchk(12'h040, 32'h00000000);
		chk(er, 1'b1);
		// Supply loss and return.
		apb(1'b1, dsleep_pkg::ADDR_GP_ZERO, 32'h0000cafe);
		mainSupplyOk <= 1'b0;
		repeat (4) @(posedge core_clk);
		chk(runFromBattery, 1'b1);
		chk(corePowerOn, 1'b0);
		chk(watchdogRun, 1'b0);
		chk(calendarPowerOn, 1'b0);
		chk(gatedRegPowerOn, 1'b1);
		chk(persistentPowerOn, 1'b1);
		mainSupplyOk <= 1'b1;
		seen = 0;
		repeat (5)
		begin
			@(posedge core_clk);
			if (powerOnResetPulse === 1'b1)
				seen++;
		end
		chk(seen, 1);
		chk(corePowerOn, 1'b1);
		rdchk(dsleep_pkg::ADDR_GP_ZERO, 32'h0000cafe);
		rdchk(dsleep_pkg::ADDR_GP_BASE, 32'h00c0ffe4);
		// Status shows the lock open and the unpaired write still held.
		unlock();
		rdchk(dsleep_pkg::ADDR_STATUS, 32'h0000000c);
		// A new value replaces the held one, then pairs and commits.
		wr2(dsleep_pkg::ADDR_CTRL, 32'h00009001);
		rdchk(dsleep_pkg::ADDR_CTRL, 32'h00009001);
		// Only live domains may wake: calendar off, watchdog on.
		waitSleepReq <= 1'b1;
		repeat (4) @(posedge core_clk);
		waitSleepReq <= 1'b0;
		chk(calendarPowerOn, 1'b0);
		calendarAlarm <= 1'b1;
		repeat (4) @(posedge core_clk);
		calendarAlarm <= 1'b0;
		chk(corePowerOn, 1'b0);
		watchdogTimeout <= 1'b1;
		repeat (4) @(posedge core_clk);
		watchdogTimeout <= 1'b0;
		chk(corePowerOn, 1'b1);
		end_sim();
	end
endmodule // deep_sleep_retention_control_tb
